// ==== rtl/gate_input_mux.sv ====
// Data input source selection and gate 0 term combination
`timescale 1ns/100ps
`default_nettype none
module gate_input_mux
#(
	parameter int SOURCE_COUNT = 64
)
(
	// Candidate signals
	input  wire logic [SOURCE_COUNT-1:0]         i_sources,
	// Configuration
	input  wire logic_cell_pkg::src_fields_t      i_src_field,
	input  wire logic [7:0]                       i_term_select,
	// Results
	output logic [logic_cell_pkg::DATA_INPUTS-1:0] o_selected,
	output logic                                   o_gate0
);
	import logic_cell_pkg::*;

	logic [DATA_INPUTS-1:0] term_hit;

	// ****************************************
	// Per input selection and gating
	// ****************************************
	for (genvar g = 0; g < DATA_INPUTS; g++)
	begin : g_input
		// field picks source
		// Out of range codes read low rather than undefined
		assign o_selected[g] = (int'(i_src_field[g]) < SOURCE_COUNT)
			? i_sources[i_src_field[g]] : 1'b0;
		assign term_hit[g] =
			(i_term_select[2*g+TERM_TRUE_OFS] & o_selected[g]) |
			(i_term_select[2*g+TERM_INV_OFS] & ~o_selected[g]);
	end

	assign o_gate0 = |term_hit;

endmodule
`default_nettype wire

// ==== rtl/logic_cell_input_gating.sv ====
// Logic cell input selection and gate 0 term selection with APB registers
`timescale 1ns/100ps
`default_nettype none
module logic_cell_input_gating
#(
	parameter int SOURCE_COUNT = 64
)
(
	// Clock, reset, enable
	input  wire logic                        i_core_clk,
	input  wire logic                        i_rst_n,
	input  wire logic                        i_clk_en,
	// APB slave
	input  wire logic_cell_pkg::apb_req_s    i_apb,
	output var  logic_cell_pkg::apb_rsp_s    o_apb,
	// Candidate signals
	input  wire logic [SOURCE_COUNT-1:0]     i_sources,
	// Cell inputs and gate
	output logic [3:0]                       o_selected_data,
	output logic                             o_gate0
);
	import logic_cell_pkg::*;

	src_fields_t            src_field;
	logic [TERM_SELECT_W-1:0] term_select;
	logic [DATA_INPUTS-1:0] next_selected;
	logic                   next_gate0;
	logic [DATA_W-1:0]      next_rdata;
	reg_index_e             req_index;
	logic                   setup_phase;
	logic                   access_fire;
	logic                   wr_fire;

	// ****************************************
	// Address decode
	// ****************************************
	function automatic reg_index_e decode_index(
		input logic [ADDR_W-1:0] addr);
		case (addr)
			DATA1_SOURCE_SELECT_OFFSET: return REG_SEL1;
			DATA2_SOURCE_SELECT_OFFSET: return REG_SEL2;
			DATA3_SOURCE_SELECT_OFFSET: return REG_SEL3;
			DATA4_SOURCE_SELECT_OFFSET: return REG_SEL4;
			GATE0_TERM_SELECT_OFFSET:   return REG_GLS;
			CELL_STATUS_OFFSET:         return REG_STATUS;
			default:                    return REG_NONE;
		endcase
	endfunction

	function automatic logic is_select_reg(input reg_index_e idx);
		return idx[2] == 1'b0;
	endfunction

	assign req_index   = decode_index(i_apb.paddr);
	assign setup_phase = i_apb.psel & ~i_apb.penable;
	assign access_fire = i_apb.psel & i_apb.penable & o_apb.pready;
	assign wr_fire     = access_fire & i_apb.pwrite & i_clk_en;

	// ****************************************
	// Read data
	// ****************************************
	always_comb
	begin
		next_rdata = '0;
		case (req_index)
			REG_SEL1, REG_SEL2, REG_SEL3, REG_SEL4:
				next_rdata[SRC_FIELD_LSB +: SRC_FIELD_W] =
					src_field[req_index[1:0]];
			REG_GLS:
				next_rdata[TERM_SELECT_W-1:0] = term_select;
			REG_STATUS:
			begin
				next_rdata[STATUS_DATA_LSB +: DATA_INPUTS] = o_selected_data;
				next_rdata[STATUS_GATE_BIT] = o_gate0;
			end
			default:
				next_rdata = '0;
		endcase
	end

	// ****************************************
	// APB response
	// ****************************************
	// No wait state; pready is registered from the setup phase so every response bit comes from a flop
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_apb <= '0;
		end
		else if (i_clk_en)
		begin
			o_apb.pready  <= setup_phase;
			o_apb.pslverr <= setup_phase & (req_index == REG_NONE);
			o_apb.prdata  <= (setup_phase & ~i_apb.pwrite)
				? next_rdata : '0;
		end
	end

	// ****************************************
	// Source select registers
	// ****************************************
	// Power-on value is unspecified; reset clears it to a known code
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			for (int n = 0; n < DATA_INPUTS; n++)
				src_field[n] <= SRC_FIELD_RESET;
		end
		else if (wr_fire && is_select_reg(req_index))
		begin
			src_field[req_index[1:0]] <=
				i_apb.pwdata[SRC_FIELD_LSB +: SRC_FIELD_W];
		end
	end

	// ****************************************
	// Gate 0 term select register
	// ****************************************
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			term_select <= TERM_RESET;
		end
		else if (wr_fire && req_index == REG_GLS)
		begin
			term_select <= i_apb.pwdata[TERM_SELECT_W-1:0];
		end
	end

	// ****************************************
	// Selection and gate
	// ****************************************
	gate_input_mux
	#(
		.SOURCE_COUNT (SOURCE_COUNT)
	)
	u_gate_input_mux
	(
		.i_sources     (i_sources),
		.i_src_field   (src_field),
		.i_term_select (term_select),
		.o_selected    (next_selected),
		.o_gate0       (next_gate0)
	);

	// registered gate output
	// Costs a cycle of latency but keeps the output glitch free
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_selected_data <= '0;
			o_gate0         <= 1'b0;
		end
		else if (i_clk_en)
		begin
			o_selected_data <= next_selected;
			o_gate0         <= next_gate0;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);

	for (genvar g = 0; g < DATA_INPUTS; g++)
	begin : g_chk_sel
		chk_sel_store:
		assert property (wr_fire && is_select_reg(req_index)
			&& req_index[1:0] == 2'(g)
			|=> src_field[g] == $past(i_apb.pwdata[5:0]))
			else $error("select field not stored");
	end

	chk_upper_zero:
	assert property (access_fire && !i_apb.pwrite
		&& is_select_reg(req_index)
		|-> o_apb.prdata[DATA_W-1:SRC_FIELD_W] == '0)
		else $error("select upper bits not zero");

	chk_term_in4:
	assert property (i_clk_en && ((term_select[7] && next_selected[3])
		|| (term_select[6] && !next_selected[3])) |=> o_gate0)
		else $error("input 4 term not gated");

	chk_term_in3:
	assert property (i_clk_en && ((term_select[5] && next_selected[2])
		|| (term_select[4] && !next_selected[2])) |=> o_gate0)
		else $error("input 3 term not gated");

	chk_term_in2:
	assert property (i_clk_en && ((term_select[3] && next_selected[1])
		|| (term_select[2] && !next_selected[1])) |=> o_gate0)
		else $error("input 2 term not gated");

	chk_term_in1:
	assert property (i_clk_en && ((term_select[1] && next_selected[0])
		|| (term_select[0] && !next_selected[0])) |=> o_gate0)
		else $error("input 1 term not gated");

	chk_term_excluded:
	assert property (i_clk_en && term_select == 8'h01
		&& next_selected[0] |=> !o_gate0)
		else $error("cleared term reached gate");

	chk_gls_readback:
	assert property (access_fire && !i_apb.pwrite && req_index == REG_GLS
		|-> o_apb.prdata[7:0] == term_select)
		else $error("term select readback wrong");

	chk_gate_idle:
	assert property (i_clk_en && term_select == 8'h00 |=> !o_gate0)
		else $error("gate high with no terms");

	chk_update_delay:
	assert property (wr_fire && req_index == REG_GLS
		&& i_apb.pwdata[7:0] == 8'h00 ##1 i_clk_en |=> !o_gate0)
		else $error("gate not updated after write");

	chk_ready_pulse:
	assert property (o_apb.pready && i_clk_en |=> !o_apb.pready)
		else $error("ready held past one cycle");

	// ****************************************
	// Bus, register, freeze, source selection and gate checks
	// ****************************************
	chk_ready_setup:
	assert property (setup_phase && i_clk_en |=> o_apb.pready)
		else $error("no ready after setup");

	chk_err_ready:
	assert property (o_apb.pslverr |-> o_apb.pready)
		else $error("error without ready");

	chk_bad_addr:
	assert property (access_fire && req_index == REG_NONE
		|-> o_apb.pslverr)
		else $error("unmapped address not refused");

	chk_good_addr:
	assert property (access_fire && req_index != REG_NONE
		|-> !o_apb.pslverr)
		else $error("mapped address refused");

	chk_rdata_idle:
	assert property (!o_apb.pready |-> o_apb.prdata == '0)
		else $error("read data outside access cycle");

	chk_term_store:
	assert property (wr_fire && req_index == REG_GLS
		|=> term_select == $past(i_apb.pwdata[TERM_SELECT_W-1:0]))
		else $error("term select not stored");

	chk_sel_readback:
	assert property (access_fire && !i_apb.pwrite
		&& is_select_reg(req_index)
		|-> o_apb.prdata[SRC_FIELD_W-1:0] == src_field[req_index[1:0]])
		else $error("select field readback wrong");

	chk_term_upper:
	assert property (access_fire && !i_apb.pwrite && req_index == REG_GLS
		|-> o_apb.prdata[DATA_W-1:TERM_SELECT_W] == '0)
		else $error("term select upper bits not zero");

	chk_status_upper:
	assert property (access_fire && !i_apb.pwrite
		&& req_index == REG_STATUS
		|-> o_apb.prdata[DATA_W-1:STATUS_GATE_BIT+1] == '0)
		else $error("status upper bits not zero");

	chk_status_write:
	assert property (wr_fire && req_index == REG_STATUS
		|=> $stable(term_select) && $stable(src_field))
		else $error("status write changed a register");

	chk_freeze_regs:
	assert property (!i_clk_en
		|=> $stable(term_select) && $stable(src_field))
		else $error("registers moved while disabled");

	chk_freeze_out:
	assert property (!i_clk_en
		|=> $stable(o_gate0) && $stable(o_selected_data))
		else $error("outputs moved while disabled");

	chk_freeze_bus:
	assert property (!i_clk_en |=> $stable(o_apb))
		else $error("bus response moved while disabled");

	for (genvar g = 0; g < DATA_INPUTS; g++)
	begin : g_chk_src
		chk_sel_source:
		assert property (i_clk_en && int'(src_field[g]) < SOURCE_COUNT
			|=> o_selected_data[g] == $past(i_sources[src_field[g]]))
			else $error("selected data not from chosen source");
	end

	chk_in4_excluded:
	assert property (i_clk_en && term_select == 8'h80
		&& !next_selected[3] |=> !o_gate0)
		else $error("cleared term reached gate");

	cov_gls_write:
	cover property (wr_fire && req_index == REG_GLS);

	cov_sel_read:
	cover property (access_fire && !i_apb.pwrite
		&& is_select_reg(req_index));

	cov_gate_rise:
	cover property (!o_gate0 ##1 o_gate0);

	cov_bad_addr:
	cover property (access_fire && o_apb.pslverr);

	cov_clk_freeze:
	cover property (!i_clk_en ##1 i_clk_en);

endmodule
`default_nettype wire

// ==== rtl/logic_cell_pkg.sv ====
// Shared constants and types for the logic cell input gating block
`default_nettype none
package logic_cell_pkg;

	// ****************************************
	// Bus widths
	// ****************************************
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [ADDR_W-1:0] DATA1_SOURCE_SELECT_OFFSET = 12'h000;
	localparam logic [ADDR_W-1:0] DATA2_SOURCE_SELECT_OFFSET = 12'h004;
	localparam logic [ADDR_W-1:0] DATA3_SOURCE_SELECT_OFFSET = 12'h008;
	localparam logic [ADDR_W-1:0] DATA4_SOURCE_SELECT_OFFSET = 12'h00c;
	localparam logic [ADDR_W-1:0] GATE0_TERM_SELECT_OFFSET   = 12'h010;
	localparam logic [ADDR_W-1:0] CELL_STATUS_OFFSET         = 12'h014;

	// ****************************************
	// Field layout and reset values
	// ****************************************
	localparam int         DATA_INPUTS      = 4;
	localparam int         SRC_FIELD_LSB    = 0;
	localparam int         SRC_FIELD_W      = 6;
	localparam int         TERM_SELECT_W    = 8;
	localparam int         TERM_TRUE_OFS    = 1;
	localparam int         TERM_INV_OFS     = 0;
	localparam int         STATUS_DATA_LSB  = 0;
	localparam int         STATUS_GATE_BIT  = 4;
	localparam logic [5:0] SRC_FIELD_RESET  = 6'h00;
	localparam logic [7:0] TERM_RESET       = 8'h00;

	// Cycles from a completed write to the gate output reflecting it
	localparam int UPDATE_LATENCY = 1;

	// ****************************************
	// Types
	// ****************************************
	typedef logic [DATA_INPUTS-1:0][SRC_FIELD_W-1:0] src_fields_t;

	typedef enum logic [2:0]
	{
		REG_SEL1   = 3'b000,
		REG_SEL2   = 3'b001,
		REG_SEL3   = 3'b010,
		REG_SEL4   = 3'b011,
		REG_GLS    = 3'b100,
		REG_STATUS = 3'b101,
		REG_NONE   = 3'b111
	} reg_index_e;

	typedef struct packed
	{
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_s;

	typedef struct packed
	{
		logic              pready;
		logic              pslverr;
		logic [DATA_W-1:0] prdata;
	} apb_rsp_s;

endpackage
`default_nettype wire

// ==== tb/logic_cell_input_gating_test.sv ====
// Self-checking bench for the logic cell input gating block
`timescale 1ns/100ps
`default_nettype none
module logic_cell_input_gating_test;
	import logic_cell_pkg::*;
	logic        clk;
	logic        rst_n;
	logic        clk_en;
	apb_req_s    req;
	apb_rsp_s    rsp;
	logic [63:0] src;
	logic [3:0]  sel;
	logic        g0;
	int          mismatches;
	int          checked;
	logic [31:0] rd;
	logic        err;
	logic [7:0]  t;
	logic [5:0]  code [4];

	logic_cell_input_gating #(.SOURCE_COUNT(64)) logic_cell_input_gating_inst
	(
		.i_core_clk      (clk),
		.i_rst_n         (rst_n),
		.i_clk_en        (clk_en),
		.i_apb           (req),
		.o_apb           (rsp),
		.i_sources       (src),
		.o_selected_data (sel),
		.o_gate0         (g0)
	);

	// ****************************************
	// Helpers
	// ****************************************
	task automatic end_sim();
		$display("Counts: checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Request held until pready is sampled high; bounded wait
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
		@(posedge clk);
		req.penable <= 1'b1;
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk);
			if (rsp.pready === 1'b1)
				break;
		end
		if (n >= 20)
		begin
			mismatches++;
			end_sim();
		end
		else
		begin
			rd = rsp.prdata;
			err = rsp.pslverr;
			req <= '0;
		end
	endtask

	task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	// Non-selected sources held high so a wrong index shows up
	task automatic drive(input logic [3:0] x);
		logic [63:0] s;
		s = ~64'h0;
		for (int i = 0; i < 4; i++)
			s[code[i]] = x[i];
		@(posedge clk);
		src <= s;
		@(posedge clk);
		#1;
	endtask

	function automatic logic gexp(input logic [7:0] tt, input logic [3:0] x);
		gexp = 1'b0;
		for (int i = 0; i < 4; i++)
			gexp = gexp | (tt[2*i+1] & x[i]) | (tt[2*i] & ~x[i]);
	endfunction

	initial
	begin
		clk = 1'b0;
		forever
			#5 clk = ~clk;
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		req = '0;
		src = '0;
		mismatches = 0;
		checked = 0;
		code = '{6'h05, 6'h11, 6'h2a, 6'h3f};
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++)
			rdchk("reset value", 12'(4*i), 32'h0);
		chk("gate after reset", 32'h0, {31'h0, g0});
		$display("Test reset done");
		for (int i = 0; i < 4; i++)
		begin
			xfer(1'b1, 12'(4*i), {26'h3ffffff, code[i]});
			rdchk("select field", 12'(4*i), {26'h0, code[i]});
		end
		for (int x = 0; x < 16; x++)
		begin
			drive(4'(x));
			chk("selected data", {28'h0, 4'(x)}, {28'h0, sel});
			chk("gate no terms", 32'h0, {31'h0, g0});
		end
		$display("Test selection done");
		for (int k = 0; k < 9; k++)
		begin
			t = (k < 8) ? (8'h01 << k) : 8'hff;
			xfer(1'b1, GATE0_TERM_SELECT_OFFSET, {24'hffffff, t});
			rdchk("term select", GATE0_TERM_SELECT_OFFSET, {24'h0, t});
			for (int x = 0; x < 16; x++)
			begin
				drive(4'(x));
				chk("gate 0", {31'h0, gexp(t, 4'(x))}, {31'h0, g0});
			end
			rdchk("status", CELL_STATUS_OFFSET, {27'h0, gexp(t, 4'hf), 4'hf});
		end
		$display("Test gate terms done");
		xfer(1'b1, GATE0_TERM_SELECT_OFFSET, 32'h0);
		drive(4'hf);
		chk("gate cleared", 32'h0, {31'h0, g0});
		xfer(1'b1, CELL_STATUS_OFFSET, 32'hffffffff);
		chk("status write error", 32'h0, {31'h0, err});
		rdchk("term kept", GATE0_TERM_SELECT_OFFSET, 32'h0);
		xfer(1'b1, 12'h018, 32'h0000003f);
		chk("unmapped write error", 32'h1, {31'h0, err});
		rdchk("unmapped read", 12'h018, 32'h0);
		chk("unmapped read error", 32'h1, {31'h0, err});
		rdchk("select kept", DATA1_SOURCE_SELECT_OFFSET, {26'h0, code[0]});
		@(posedge clk);
		clk_en <= 1'b0;
		src <= '0;
		repeat (3) @(posedge clk);
		#1;
		chk("frozen outputs", 32'hf, {28'h0, sel});
		@(posedge clk);
		clk_en <= 1'b1;
		@(posedge clk);
		#1;
		chk("resumed outputs", 32'h0, {28'h0, sel});
		$display("Test refusals and freeze done");
		end_sim();
	end
endmodule
`default_nettype wire
